// *** rtl/egress_sched.sv ***
// Port 1 egress queue scheduler with its weight and threshold registers.
// Assumes register port, queue status and slot strobe come from core_clk_i logic.
`timescale 1ns/10ps
`include "egress_sched_regs.svh"

module egress_sched (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rdata_valid_o,
  input wire logic global_prio_sel_i,
  input wire logic two_queue_mode_i,
  input wire logic [3:0] queue_ready_i,
  input wire logic tx_slot_i,
  output logic [3:0] grant_o,
  output logic grant_valid_o,
  output logic [1:0] sched_mode_o
);

  localparam egress_sched_pkg::weight_t WEIGHT_TBL [0:3] = '{
    `WEIGHT_QUEUE0, `WEIGHT_QUEUE1, `WEIGHT_QUEUE2, `WEIGHT_QUEUE3
  };

  ////////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [3:0] sel_ff;
  logic [3:0] nxt_sel;
  egress_sched_pkg::reg_byte_t rdata_ff;
  egress_sched_pkg::reg_byte_t nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;

  // Only the select bit is writable; the weight fields are fixed
  always_comb begin
    nxt_sel = sel_ff;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `ADDR_P1_QUEUE3_WEIGHT: nxt_sel[3] = reg_wdata_i[`SCHED_SEL_BIT];
        `ADDR_P1_QUEUE2_WEIGHT: nxt_sel[2] = reg_wdata_i[`SCHED_SEL_BIT];
        `ADDR_P1_QUEUE1_WEIGHT: nxt_sel[1] = reg_wdata_i[`SCHED_SEL_BIT];
        `ADDR_P1_QUEUE0_WEIGHT: nxt_sel[0] = reg_wdata_i[`SCHED_SEL_BIT];
        default: nxt_sel = sel_ff;
      endcase
    end
    // Read data one cycle after the strobe; unmapped offsets read zero
    nxt_rvalid = reg_rd_i;
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `ADDR_PAUSE_THR_MODE2: nxt_rdata = `RST_PAUSE_THR_MODE2;
        `ADDR_PAUSE_THR_MODE3: nxt_rdata = `RST_PAUSE_THR_MODE3;
        `ADDR_PAUSE_THR_MODE4: nxt_rdata = `RST_PAUSE_THR_MODE4;
        `ADDR_P1_QUEUE3_WEIGHT: nxt_rdata = {sel_ff[3], `WEIGHT_QUEUE3};
        `ADDR_P1_QUEUE2_WEIGHT: nxt_rdata = {sel_ff[2], `WEIGHT_QUEUE2};
        `ADDR_P1_QUEUE1_WEIGHT: nxt_rdata = {sel_ff[1], `WEIGHT_QUEUE1};
        `ADDR_P1_QUEUE0_WEIGHT: nxt_rdata = {sel_ff[0], `WEIGHT_QUEUE0};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Selects come up set so the port starts in weighted service
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_ff <= `RST_SCHED_SEL;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      sel_ff <= nxt_sel;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode selection

  egress_sched_pkg::sched_mode_e mode_ff;
  egress_sched_pkg::sched_mode_e nxt_mode;

  // Any set select or the global bit keeps weighted service; strict needs all clear
  always_comb begin
    if ((sel_ff == 4'h0) && !global_prio_sel_i) begin
      nxt_mode = egress_sched_pkg::MODE_STRICT;
    end else if (two_queue_mode_i) begin
      nxt_mode = egress_sched_pkg::MODE_WRR2;
    end else begin
      nxt_mode = egress_sched_pkg::MODE_WRR4;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_ff <= egress_sched_pkg::MODE_WRR4;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Grant selection

  logic [3:0] used;
  logic weighted;
  logic [3:0] pend;
  logic [3:0] credit_ok;
  logic has_ok;
  logic [3:0] cand;
  logic reload;
  logic [3:0] take;
  logic [3:0] grant_ff;
  logic [3:0] nxt_grant;
  logic gvalid_ff;
  logic nxt_gvalid;

  // Highest numbered queue has the highest priority
  function automatic logic [3:0] pick_top(input logic [3:0] req);
    logic [3:0] one;
    one = 4'h0;
    if (req[3]) one = 4'h8;
    else if (req[2]) one = 4'h4;
    else if (req[1]) one = 4'h2;
    else if (req[0]) one = 4'h1;
    return one;
  endfunction

  // Discipline per mode; in two-queue use only queues 1 and 0 carry traffic
  always_comb begin
    used = two_queue_mode_i ? `TWO_QUEUE_MASK : `ALL_QUEUE_MASK;
    case (mode_ff)
      egress_sched_pkg::MODE_STRICT: weighted = 1'b0;
      egress_sched_pkg::MODE_WRR4: weighted = 1'b1;
      egress_sched_pkg::MODE_WRR2: weighted = 1'b1;
      default: weighted = 1'b1;
    endcase
    // In weighted modes queues with credit go first; when no pending queue has credit a new round starts
    pend = queue_ready_i & used;
    has_ok = |(pend & credit_ok);
    cand = (weighted && has_ok) ? (pend & credit_ok) : pend;
    reload = tx_slot_i && weighted && (pend != 4'h0) && !has_ok;
    nxt_gvalid = tx_slot_i && (pend != 4'h0);
    nxt_grant = nxt_gvalid ? pick_top(cand) : 4'h0;
    take = weighted ? nxt_grant : 4'h0;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      grant_ff <= 4'h0;
      gvalid_ff <= 1'b0;
    end else begin
      grant_ff <= nxt_grant;
      gvalid_ff <= nxt_gvalid;
    end
  end

  // One credit counter per queue, each loaded with its own weight
  genvar q;
  generate
    for (q = 0; q < 4; q++) begin : g_credit
      sched_credit #(
        .WEIGHT(WEIGHT_TBL[q])
      ) u_credit (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .load_i(reload),
        .take_i(take[q]),
        .credit_ok_o(credit_ok[q])
      );
    end
  endgenerate

  assign reg_rdata_o = rdata_ff;
  assign reg_rdata_valid_o = rvalid_ff;
  assign grant_o = grant_ff;
  assign grant_valid_o = gvalid_ff;
  assign sched_mode_o = mode_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_strict_highest_first: assert property (
    grant_valid_o && ($past(mode_ff) == egress_sched_pkg::MODE_STRICT)
      |-> grant_o == pick_top($past(pend)))
    else $error("strict grant is not the highest pending queue");

  a_credit_queue_first: assert property (
    $past(tx_slot_i && weighted && has_ok)
      |-> (grant_o & $past(pend & credit_ok)) != 4'h0)
    else $error("weighted grant skipped a queue holding credit");

  a_two_queue_only: assert property (
    grant_valid_o && $past(two_queue_mode_i) |-> grant_o[3:2] == 2'b00)
    else $error("two-queue mode granted an unused queue");

  a_weight_field_ro: assert property (
    ($past(reg_rd_i) && ($past(reg_addr_i) == `ADDR_P1_QUEUE3_WEIGHT)) ##0 reg_rdata_valid_o
      |-> reg_rdata_o[6:0] == `WEIGHT_QUEUE3)
    else $error("queue three weight field changed");

  a_weight_low_ro: assert property (
    $past(reg_rd_i) && ($past(reg_addr_i) == `ADDR_P1_QUEUE0_WEIGHT)
      |-> reg_rdata_o == {$past(sel_ff[0]), `WEIGHT_QUEUE0})
    else $error("queue zero register read wrong");

  a_threshold_ro: assert property (
    $past(reg_rd_i) && ($past(reg_addr_i) == `ADDR_PAUSE_THR_MODE4)
      |-> reg_rdata_o == `RST_PAUSE_THR_MODE4)
    else $error("mode four threshold read wrong");

  a_select_reset: assert property (
    $past(sys_rst_i) |-> (sel_ff == `RST_SCHED_SEL) && (grant_valid_o == 1'b0))
    else $error("selects not set after reset");

  a_grant_follows_slot: assert property (
    tx_slot_i && (pend != 4'h0) |=> grant_valid_o && $onehot(grant_o))
    else $error("slot with pending queue gave no single grant");

  c_strict_grant: cover property (
    grant_valid_o && (mode_ff == egress_sched_pkg::MODE_STRICT));
  c_wrr4_reload: cover property (
    reload && (mode_ff == egress_sched_pkg::MODE_WRR4));
  c_wrr2_grant: cover property (
    grant_valid_o && (mode_ff == egress_sched_pkg::MODE_WRR2));

endmodule

// *** rtl/egress_sched_pkg.sv ***
// Types shared by the port 1 egress scheduler files.
// Assumes nothing beyond a SystemVerilog compiler.
package egress_sched_pkg;

  // Service discipline currently in force
  typedef enum logic [1:0] {
    MODE_STRICT = 2'b00,
    MODE_WRR4 = 2'b01,
    MODE_WRR2 = 2'b10
  } sched_mode_e;

  typedef logic [7:0] reg_byte_t;
  typedef logic [6:0] weight_t;

endpackage

// *** rtl/egress_sched_regs.svh ***
// Register offsets, reset values and field positions of the port 1 egress scheduler.
// Assumes inclusion by bare name from design files of the same block.
`ifndef EGRESS_SCHED_REGS_SVH
`define EGRESS_SCHED_REGS_SVH

// Register offsets (byte addresses on the management register port)
`define ADDR_PAUSE_THR_MODE2 8'hAC
`define ADDR_PAUSE_THR_MODE3 8'hAD
`define ADDR_PAUSE_THR_MODE4 8'hAE
`define ADDR_P1_QUEUE3_WEIGHT 8'hAF
`define ADDR_P1_QUEUE2_WEIGHT 8'hB0
`define ADDR_P1_QUEUE1_WEIGHT 8'hB1
`define ADDR_P1_QUEUE0_WEIGHT 8'hB2

// Read-only threshold values, low fields, upper bits read zero
`define RST_PAUSE_THR_MODE2 8'h10
`define RST_PAUSE_THR_MODE3 8'h08
`define RST_PAUSE_THR_MODE4 8'h05

// Read-only weight fields, bits 6..0
`define WEIGHT_QUEUE3 7'h08
`define WEIGHT_QUEUE2 7'h04
`define WEIGHT_QUEUE1 7'h02
`define WEIGHT_QUEUE0 7'h01

// Schedule select bit position and reset value of all four selects
`define SCHED_SEL_BIT 7
`define RST_SCHED_SEL 4'hF

// Queues in use when the port runs two or all four transmit queues
`define TWO_QUEUE_MASK 4'h3
`define ALL_QUEUE_MASK 4'hF

`endif

// *** rtl/sched_credit.sv ***
// One queue's service credit counter for weighted egress service.
// Assumes load and take arrive from logic on the same clock.
`timescale 1ns/10ps

module sched_credit #(
  parameter egress_sched_pkg::weight_t WEIGHT = 7'h01
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic take_i,
  output logic credit_ok_o
);

  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;

  // Reload wins over a plain take; a take in the reload cycle uses one credit
  always_comb begin
    nxt_cnt = cnt_ff;
    if (load_i) begin
      nxt_cnt = take_i ? WEIGHT - 7'h01 : WEIGHT;
    end else if (take_i && (cnt_ff != 7'h00)) begin
      nxt_cnt = cnt_ff - 7'h01;
    end
  end

  // Starts full so the first round after reset has its share
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_ff <= WEIGHT;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign credit_ok_o = (cnt_ff != 7'h00);

endmodule

// *** testbench/egress_sched_tb_top.sv ***
// Self-checking bench for the port 1 egress scheduler and its registers.
// Assumes the design files under rtl/ and the register header on the include path.
`timescale 1ns/10ps
`include "egress_sched_regs.svh"

module egress_sched_tb_top;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic reg_rdata_valid_o;
  logic global_prio_sel_i = 1'b0;
  logic two_queue_mode_i = 1'b0;
  logic [3:0] queue_ready_i = 4'h0;
  logic tx_slot_i = 1'b0;
  logic [3:0] grant_o;
  logic grant_valid_o;
  logic [1:0] sched_mode_o;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int cr[4];
  logic [31:0] seed = 32'h09ED;
  logic [1:0] mode_m;
  logic [7:0] rv;

  egress_sched egress_sched_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rdata_valid_o(reg_rdata_valid_o),
    .global_prio_sel_i(global_prio_sel_i), .two_queue_mode_i(two_queue_mode_i),
    .queue_ready_i(queue_ready_i), .tx_slot_i(tx_slot_i), .grant_o(grant_o),
    .grant_valid_o(grant_valid_o), .sched_mode_o(sched_mode_o));

  // 40 MHz core clock
  always #12.5 core_clk_i = ~core_clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Checking and reporting
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Ceiling well above the roughly 400 cycles the tests need
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      stop_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected register byte at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_grant(input logic [4:0] got, input logic [4:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected grant at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_mode(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected mode at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Register port strobes, one cycle each plus an idle cycle, driven at the falling edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
    @(negedge core_clk_i); // Idle gap so a following call never re-raises in one step
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    chk_reg({7'h00, reg_rdata_valid_o}, 8'h01);
    d = reg_rdata_o;
    @(negedge core_clk_i);
  endtask

  // Bench copy of the scheduler: strict, or credits reloaded 8,4,2,1 when no pending queue has any left
  task automatic exp_grant(input logic [3:0] rdy, output logic [3:0] g);
    logic [3:0] pend;
    logic [3:0] el;
    int hi;
    pend = rdy & (two_queue_mode_i ? 4'h3 : 4'hF);
    el = 4'h0;
    hi = 0;
    g = 4'h0;
    for (int q = 0; q < 4; q++) if (pend[q] && cr[q] > 0) el[q] = 1'b1;
    if (mode_m == egress_sched_pkg::MODE_STRICT) el = pend;
    else if (el == 4'h0 && pend != 4'h0) begin
      cr = '{1, 2, 4, 8};
      el = pend;
    end
    for (int q = 0; q < 4; q++) if (el[q]) hi = q;
    if (pend != 4'h0) begin
      g = 4'h1 << hi;
      if (mode_m != egress_sched_pkg::MODE_STRICT) cr[hi]--;
    end
  endtask

  // Back to back slots; all queues ready when full is set, random readiness otherwise
  task automatic run_slots(input int n, input bit full);
    logic [3:0] g;
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      queue_ready_i = full ? 4'hF : seed[3:0];
      tx_slot_i = 1'b1;
      exp_grant(queue_ready_i, g);
      @(negedge core_clk_i);
      chk_grant({grant_valid_o, grant_o}, {g != 4'h0, g});
    end
    tx_slot_i = 1'b0;
    @(negedge core_clk_i);
  endtask

  // Selects written with random low bits, which the port must ignore
  task automatic set_cfg(input logic [3:0] s, input logic glb, input logic two);
    for (int q = 0; q < 4; q++) begin
      seed = xs(seed);
      reg_wr(`ADDR_P1_QUEUE0_WEIGHT - q, {s[q], seed[6:0]});
    end
    global_prio_sel_i = glb;
    two_queue_mode_i = two;
    mode_m = (s == 4'h0 && !glb) ? 2'b00 : (two ? 2'b10 : 2'b01);
    repeat (3) @(negedge core_clk_i);
    chk_mode(sched_mode_o, mode_m);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] exp_tab[8];
    exp_tab = '{8'h10, 8'h08, 8'h05, 8'h88, 8'h84, 8'h82, 8'h81, 8'h00};
    cr = '{1, 2, 4, 8};
    mode_m = 2'b01;
    repeat (6) @(posedge core_clk_i);
    @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    @(negedge core_clk_i);
    chk_mode(sched_mode_o, 2'b01);
    for (int i = 0; i < 8; i++) begin
      reg_rd(`ADDR_PAUSE_THR_MODE2 + i, rv);
      chk_reg(rv, exp_tab[i]);
    end
    $display("test reset values done");
    for (int i = 0; i < 7; i++) reg_wr(`ADDR_PAUSE_THR_MODE2 + i, 8'hFF);
    for (int i = 0; i < 7; i++) begin
      reg_rd(`ADDR_PAUSE_THR_MODE2 + i, rv);
      chk_reg(rv, exp_tab[i]);
    end
    reg_wr(`ADDR_P1_QUEUE0_WEIGHT, 8'h00);
    reg_rd(`ADDR_P1_QUEUE0_WEIGHT, rv);
    chk_reg(rv, 8'h01);
    reg_wr(`ADDR_P1_QUEUE0_WEIGHT, 8'h80);
    $display("test read-only fields done");
    run_slots(30, 1'b1);
    run_slots(80, 1'b0);
    $display("test weighted four queues done");
    set_cfg(4'hF, 1'b0, 1'b1);
    run_slots(9, 1'b1);
    run_slots(40, 1'b0);
    $display("test weighted two queues done");
    set_cfg(4'h0, 1'b0, 1'b0);
    run_slots(40, 1'b0);
    set_cfg(4'h0, 1'b0, 1'b1);
    run_slots(20, 1'b0);
    $display("test strict order done");
    set_cfg(4'h0, 1'b1, 1'b0);
    run_slots(30, 1'b0);
    set_cfg(4'h4, 1'b0, 1'b0);
    run_slots(30, 1'b0);
    $display("test mixed selects done");
    stop_test();
  end
endmodule
